// ==== cal_store.sv ====
// cal_store.sv: two registered calibration result words, one per frequency set
// assumes: a soft reset of the registers does not touch this store
`default_nettype none
module cal_store (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  cal_store_if.store  sp
);
  logic [7:0] first_r;  // result for first set
  logic [7:0] second_r; // result for second set

  // results only change on a finished calibration pass or a hard reset, never on soft reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_r  <= 8'h00;
      second_r <= 8'h00;
    end else if (sp.wr_en) begin
      if (sp.wr_sel) second_r <= sp.wr_data;
      else           first_r  <= sp.wr_data;
    end
  end
  assign sp.rd_first  = first_r;
  assign sp.rd_second = second_r;
endmodule // cal_store
`default_nettype wire

// ==== cal_store_if.sv ====
// cal_store_if.sv: write and read port of the calibration result store
// assumes: single clock domain
`default_nettype none
interface cal_store_if;
  logic      wr_en;   // write one result
  logic      wr_sel;  // which frequency set
  logic [7:0] wr_data; // result word
  logic [7:0] rd_first;  // stored result, first set
  logic [7:0] rd_second; // stored result, second set
  modport ctrl  (output wr_en, output wr_sel, output wr_data, input rd_first, input rd_second);
  modport store (input wr_en, input wr_sel, input wr_data, output rd_first, output rd_second);
endinterface
`default_nettype wire

// ==== lock_model.sv ====
// lock_model.sv: behavioural pll lock indication seen by the synthesizer controller
// assumes: one clock; the controller synchronises lock_in itself
`default_nettype none
module lock_model #(
  parameter int LOCK_DLY = 40 // cycles for the loop to settle
) (
  input  wire logic core_clk,
  input  wire logic pd_synth,
  input  wire logic fset_sel,
  input  wire logic fail,
  output var  logic lock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt   = 0;    // cycles since power-up or retune
  logic sel_q = 1'b0; // frequency set seen last cycle
  // relock count restarts on synth power-down and on a set switch
  always @(posedge core_clk) begin
    sel_q <= fset_sel;
    if (pd_synth || sel_q != fset_sel) begin
      cnt <= 0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // a failed calibration leaves the loop unlocked
  assign lock_in = !pd_synth && !fail && cnt >= LOCK_DLY;
endmodule // lock_model
`default_nettype wire

// ==== pll_calibration_power_control_bench.sv ====
// pll_calibration_power_control_bench.sv: self-checking bench for synth_ctrl
// assumes: US_CYCLES=1 so one microsecond is one cycle; lock_model on lock_in
`default_nettype none
module pll_calibration_power_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} row_t;
  logic       core_clk = 1'b0; // 100 MHz
  logic       rst_n    = 1'b0; // sync, active low
  logic       wr_stb   = 1'b0;
  logic       rd_stb   = 1'b0;
  logic       fail     = 1'b0; // makes the loop stay unlocked
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic [7:0] rdata, buf_bias, chan_word, cal_word, rv;
  logic       status_pin, pd_tx, pd_synth, pd_xosc, fset_sel, lock_in;
  logic [3:0] osc_bias;
  logic [2:0] vco_target;
  int         bad_count = 0;
  int         n_checks  = 0;
  int         n;
  int         tw[4]     = '{1000, 1500, 2900, 3900}; // fast wait times
  // write, then read back: address, data, expected read
  row_t rows[7] = '{'{8'h02, 8'ha5, 8'ha5}, '{8'h03, 8'h3c, 8'h3c},
    '{8'h06, 8'h5a, 8'h5a}, '{8'h07, 8'hc3, 8'hc3}, '{8'h20, 8'hff, 8'h00},
    '{8'h01, 8'h35, 8'h35}, '{8'h04, 8'h01, 8'h01}};
  logic [7:0] dflt[5] = '{8'h1e, 8'h35, 8'h88, 8'h04, 8'h00}; // reset values
  synth_ctrl #(.US_CYCLES(1), .NORMAL_X(2)) synth_ctrl_inst (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .lock_in(lock_in), .status_pin(status_pin),
    .pd_tx(pd_tx), .pd_synth(pd_synth), .pd_xosc(pd_xosc), .fset_sel(fset_sel),
    .osc_bias(osc_bias), .buf_bias(buf_bias), .vco_target(vco_target),
    .chan_word(chan_word), .cal_word(cal_word));
  lock_model #(.LOCK_DLY(40)) lock_model_inst (
    .core_clk(core_clk), .pd_synth(pd_synth), .fset_sel(fset_sel), .fail(fail), .lock_in(lock_in));
  // free-running clock
  always #5 core_clk = ~core_clk;
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // single closing point
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // let k edges pass, then step off the edge
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait for the status pin level
  task automatic wait_pin(input logic lv, input int lim, output int cyc);
    cyc = 0;
    #1;
    while (status_pin !== lv) begin
      tick(1);
      cyc++;
      if (cyc > lim) begin
        bad_count++;
        print_verdict();
      end
    end
  endtask
  // start a calibration and time it on the pin (source must be done flag)
  task automatic cal(input logic [7:0] cw, input int t);
    wr(8'h01, cw);
    tick(3);
    check(status_pin, 1'b0);
    wait_pin(1'b1, t + 200, n);
    check(n + 3 >= t - 16 && n + 3 <= t + 16, 1'b1);
    tick(20);
    check(status_pin, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(8'h00, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      check(rv, rows[i].r);
    end
    tick(3);
    check(status_pin, 1'b1);
    check(buf_bias, 8'h3c);
    check({osc_bias, chan_word}, {4'h5, 8'h5a});
    wr(8'h04, 8'h00);
    tick(3);
    check(status_pin, 1'b0);
    wr(8'h00, 8'h03);
    tick(2);
    check({fset_sel, osc_bias, chan_word}, {1'b1, 4'ha, 8'hc3});
    wr(8'h00, 8'h1d);
    tick(2);
    check({pd_xosc, pd_synth, pd_tx, fset_sel}, 4'he);
    wr(8'h00, 8'h15);
    tick(2);
    check({pd_xosc, pd_synth, pd_tx, fset_sel}, 4'ha);
    wr(8'h00, 8'h01);
    $display("register and output test done");
    wr(8'h04, 8'h05);
    for (int w = 0; w < 4; w++) begin
      cal({2'b10, w[1:0], 4'b1010}, tw[w]);
      check(cal_word, {2'b00, w[1:0], 4'b1010});
      check(vco_target, 3'h2);
      rd(8'h05, rv);
      check({rv[7], rv[0]}, 2'b10);
    end
    cal(8'h81, 2000);
    check(cal_word, 8'h01);
    wr(8'h02, 8'h77);
    cal(8'hcd, 2000);
    check(cal_word, 8'h0d);
    wr(8'h00, 8'h03);
    tick(2);
    check(cal_word, 8'h0d);
    cal(8'h9e, 1500);
    check(cal_word, 8'h1e);
    wr(8'h00, 8'h01);
    tick(2);
    check(cal_word, 8'h0d);
    $display("calibration test done");
    wr(8'h01, 8'hb8);
    tick(100);
    wr(8'h01, 8'hb8);
    wait_pin(1'b1, 4200, n);
    check(n + 101 >= 3884 && n + 101 <= 3916, 1'b1);
    $display("restart refusal test done");
    wr(8'h04, 8'h02);
    wait_pin(1'b1, 6000, n);
    rd(8'h05, rv);
    check(rv[4], 1'b1);
    fail <= 1'b1;
    tick(6);
    check(status_pin, 1'b0);
    fail <= 1'b0;
    $display("lock test done");
    wr(8'h00, 8'h00);
    tick(2);
    rd(8'h02, rv);
    check(rv, 8'h88);
    check(cal_word, 8'h1e);
    rd(8'h05, rv);
    check(rv[7], 1'b1);
    wr(8'h00, 8'h01);
    $display("soft reset test done");
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    check(status_pin, 1'b0);
    foreach (dflt[i]) begin
      rd(i[7:0], rv);
      check(rv, dflt[i]);
    end
    rd(8'h05, rv);
    check(rv[7], 1'b0);
    $display("hard reset test done");
    print_verdict();
  end
endmodule // pll_calibration_power_control_bench
`default_nettype wire

// ==== synth_ctrl.sv ====
// synth_ctrl.sv: synthesizer calibration, frequency set, bias and power-down control
// assumes: plain register port, lock_in is an asynchronous analog indication
`include "synth_ctrl_regs.svh"
`default_nettype none
module synth_ctrl
  import synth_ctrl_pkg::*;
#(
  parameter int US_CYCLES = `CLK_MHZ, // cycles per microsecond, lower to shorten sims
  parameter int NORMAL_X  = 2         // normal routine length as multiple of fast
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       lock_in,
  output logic            status_pin,
  output logic            pd_tx,
  output logic            pd_synth,
  output logic            pd_xosc,
  output logic            fset_sel,
  output logic      [3:0] osc_bias,
  output logic      [7:0] buf_bias,
  output logic      [2:0] vco_target,
  output logic      [7:0] chan_word,
  output logic      [7:0] cal_word
);
  localparam int CYC_W = 24; // wide enough for 4 x 3900 us at 100 cycles/us

  // elaboration check: the counters must hold the longest normal run and the turn-on mask
  if (US_CYCLES < 1 || NORMAL_X < 1 || NORMAL_X > 4 ||
      longint'(`CAL_US_W3) * US_CYCLES * NORMAL_X >= (longint'(1) << CYC_W) ||
      longint'(`TURN_ON_US) * US_CYCLES >= (longint'(1) << CYC_W)) begin : bad_params_g
    $error("unsupported synth_ctrl parameters");
  end
  localparam logic [CYC_W-1:0] CAL_CYC0 = CYC_W'(`CAL_US_W0 * US_CYCLES);
  localparam logic [CYC_W-1:0] CAL_CYC1 = CYC_W'(`CAL_US_W1 * US_CYCLES);
  localparam logic [CYC_W-1:0] CAL_CYC2 = CYC_W'(`CAL_US_W2 * US_CYCLES);
  localparam logic [CYC_W-1:0] CAL_CYC3 = CYC_W'(`CAL_US_W3 * US_CYCLES);
  localparam logic [CYC_W-1:0] SETTLE_CYC = CYC_W'(`FSET_SETTLE_US * US_CYCLES);
  localparam logic [CYC_W-1:0] TURNON_CYC = CYC_W'(`TURN_ON_US * US_CYCLES);

  // software registers
  logic [7:0] main_r;      // power-down, set select, soft reset
  logic [7:0] cal_r;       // calibration control
  logic [7:0] osc_r;       // oscillator bias, two nibbles
  logic [7:0] buf_r;       // amplifier buffer bias register
  logic [3:0] pin_src_r;   // status pin source
  logic [7:0] chan1_r;     // channel_word_first
  logic [7:0] chan2_r;     // channel_word_second
  logic       done_r;      // calibration done flag
  logic [7:0] rdata_r;     // registered read data
  logic       lock_s1_r;   // lock synchroniser stage 1
  logic       lock_s2_r;   // lock synchroniser stage 2
  logic       lock_r;      // continuous lock indication
  logic [CYC_W-1:0] cnt_r; // calibration pass down-counter
  logic [CYC_W-1:0] settle_r; // settle counter, lock masked while nonzero
  logic       fset_q_r;    // previous set select
  logic       pds_q_r;     // previous synth power-down
  cal_state_t state_r;     // calibration sequencer
  cal_state_t state_nxt;

  cal_store_if sp ();
  cal_store u_store (.core_clk(core_clk), .rst_n(rst_n), .sp(sp));

  // decoding, all continuous
  wire soft_rst   = !main_r[`MAIN_SOFT_RST_N];            // active when bit cleared
  wire wr_main    = wr_stb && addr == `OFS_MAIN;
  wire wr_cal     = wr_stb && addr == `OFS_CALIBRATE;
  wire cal_go     = wr_cal && wdata[`CAL_GO] && !soft_rst;
  // the go write carries the routine, so its length comes from the write data, not the old register
  wire [7:0] cal_cfg = cal_go ? {1'b0, wdata[6:0]} : cal_r;
  wire dual       = cal_cfg[`CAL_DUAL_BIT];
  wire fast       = cal_cfg[`CAL_FAST_BIT];
  wire [1:0] wsel = cal_cfg[`CAL_WAIT_HI:`CAL_WAIT_LO];
  wire [CYC_W-1:0] fast_len = (wsel == 2'b00) ? CAL_CYC0 : (wsel == 2'b01) ? CAL_CYC1 :
                              (wsel == 2'b10) ? CAL_CYC2 : CAL_CYC3;
  wire [CYC_W-1:0] cal_len = fast ? fast_len : CYC_W'(fast_len * NORMAL_X);
  wire cnt_zero   = cnt_r == '0;
  wire running    = state_r != CAL_IDLE;
  wire cur_set    = (state_r == CAL_RUN_SECOND) ? 1'b1 : (dual ? 1'b0 : main_r[`MAIN_FSET_SEL]);
  wire finish     = running && cnt_zero && state_nxt == CAL_IDLE;
  // result word: target voltage code and wait code of the run
  wire [7:0] result = {2'b00, wsel, fast, cal_r[`CAL_ITER_HI:`CAL_ITER_LO]};

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CAL_IDLE:       if (cal_go) state_nxt = CAL_RUN_FIRST;
      CAL_RUN_FIRST:  if (cnt_zero) state_nxt = dual ? CAL_RUN_SECOND : CAL_IDLE;
      CAL_RUN_SECOND: if (cnt_zero) state_nxt = CAL_IDLE;
    endcase
  end

  // store write on each finished pass; dual writes both sets
  assign sp.wr_en   = running && cnt_zero;
  assign sp.wr_sel  = cur_set;
  assign sp.wr_data = result;

  // register writes in any order; soft reset restores defaults
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      main_r    <= `MAIN_RST;
      cal_r     <= `CAL_RST;
      osc_r     <= `OSC_BIAS_RST;
      buf_r     <= `BUF_BIAS_RST;
      pin_src_r <= `PIN_SRC_RST;
      chan1_r   <= 8'h00;
      chan2_r   <= 8'h00;
    end else if (soft_rst && !wr_main) begin
      main_r    <= `MAIN_RST;
      cal_r     <= `CAL_RST;
      osc_r     <= `OSC_BIAS_RST;
      buf_r     <= `BUF_BIAS_RST;
      pin_src_r <= `PIN_SRC_RST;
      chan1_r   <= 8'h00;
      chan2_r   <= 8'h00;
    end else if (wr_stb) begin
      if (addr == `OFS_MAIN)        main_r    <= wdata;
      if (addr == `OFS_CALIBRATE)   cal_r     <= {1'b0, wdata[6:0]};    // go bit self-clears
      if (addr == `OFS_OSC_BIAS)    osc_r     <= wdata;
      if (addr == `OFS_BUF_BIAS)    buf_r     <= wdata;
      if (addr == `OFS_PIN_SRC)     pin_src_r <= wdata[3:0];
      if (addr == `OFS_CHAN_FIRST)  chan1_r   <= wdata;
      if (addr == `OFS_CHAN_SECOND) chan2_r   <= wdata;
    end
  end

  // sequencer and its counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= CAL_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (!running && cal_go) cnt_r <= cal_len - 1'b1;
      else if (running && cnt_zero && state_nxt != CAL_IDLE) cnt_r <= cal_len - 1'b1;
      else if (!cnt_zero) cnt_r <= cnt_r - 1'b1;
    end
  end

  // done flag: start clears it, finish sets it; finish wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) done_r <= 1'b0;
    else if (finish) done_r <= 1'b1;
    else if (cal_go) done_r <= 1'b0;
  end

  // lock synchroniser, masked during calibration and settling
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      lock_r    <= 1'b0;
      settle_r  <= '0;
      fset_q_r  <= 1'b0;
      pds_q_r   <= 1'b1;
    end else begin
      lock_s1_r <= lock_in;
      lock_s2_r <= lock_s1_r;
      fset_q_r  <= main_r[`MAIN_FSET_SEL];
      pds_q_r   <= main_r[`MAIN_PD_SYNTH];
      if (pds_q_r && !main_r[`MAIN_PD_SYNTH]) settle_r <= TURNON_CYC;
      else if (fset_q_r != main_r[`MAIN_FSET_SEL]) settle_r <= SETTLE_CYC;
      else if (settle_r != '0) settle_r <= settle_r - 1'b1;
      // the cycle of a switch or power-up is masked too, before the settle count is loaded
      lock_r <= lock_s2_r && !running && settle_r == '0 && !main_r[`MAIN_PD_SYNTH] && !pds_q_r &&
                fset_q_r == main_r[`MAIN_FSET_SEL];
    end
  end

  // status pin source select
  always_ff @(posedge core_clk) begin
    if (!rst_n) status_pin <= 1'b0;
    else begin
      unique case (pin_src_r)
        `PIN_LOW:      status_pin <= 1'b0;
        `PIN_HIGH:     status_pin <= 1'b1;
        `PIN_LOCK:     status_pin <= lock_r;
        `PIN_CAL_DONE: status_pin <= done_r;
        default:       status_pin <= 1'b0;
      endcase
    end
  end

  // read mux, data in the cycle after the strobe
  wire [7:0] status_val = {done_r, 2'b00, lock_r, 3'b000, running};
  wire [7:0] rd_mux = (addr == `OFS_MAIN)        ? main_r :
                      (addr == `OFS_CALIBRATE)   ? cal_r :
                      (addr == `OFS_OSC_BIAS)    ? osc_r :
                      (addr == `OFS_BUF_BIAS)    ? buf_r :
                      (addr == `OFS_PIN_SRC)     ? {4'h0, pin_src_r} :
                      (addr == `OFS_STATUS)      ? status_val :
                      (addr == `OFS_CHAN_FIRST)  ? chan1_r :
                      (addr == `OFS_CHAN_SECOND) ? chan2_r : 8'h00;
  always_ff @(posedge core_clk) begin
    if (!rst_n) rdata_r <= 8'h00;
    else        rdata_r <= rd_stb ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;

  // outputs to the analog side
  assign pd_tx      = main_r[`MAIN_PD_TX];
  assign pd_synth   = main_r[`MAIN_PD_SYNTH];
  assign pd_xosc    = main_r[`MAIN_PD_XOSC];
  assign fset_sel   = main_r[`MAIN_FSET_SEL];
  assign osc_bias   = fset_sel ? osc_r[7:4] : osc_r[3:0];
  assign buf_bias   = buf_r;
  assign vco_target = cal_r[`CAL_ITER_HI:`CAL_ITER_LO];
  assign chan_word  = fset_sel ? chan2_r : chan1_r;
  assign cal_word   = fset_sel ? sp.rd_second : sp.rd_first;

  // pass length helper: running cycles of the current pass against the length it was given
  logic [CYC_W-1:0] pass_cyc_r; // running cycles since the pass began
  logic [CYC_W-1:0] pass_len_r; // length loaded at the start of the pass
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pass_cyc_r <= '0;
      pass_len_r <= '0;
    end else if ((!running && cal_go) || sp.wr_en) begin
      pass_cyc_r <= '0;
      pass_len_r <= cal_len;
    end else if (running) begin
      pass_cyc_r <= pass_cyc_r + 1'b1;
    end
  end

  // assertions: sequences for the start and the end of a run
  sequence go_s;
    !running && cal_go;
  endsequence
  sequence end_s;
    finish;
  endsequence
  // done flag
  start_clears_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    go_s |=> !done_r && running) else $error("start did not clear done");
  finish_sets_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    end_s |=> done_r && !running) else $error("done not set at finish");
  done_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    done_r && !cal_go |=> done_r) else $error("done dropped without start");
  // status pin sources
  pin_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_src_r == `PIN_LOW && $stable(pin_src_r) |=> !status_pin) else $error("pin not low");
  pin_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_src_r == `PIN_HIGH && $stable(pin_src_r) |=> status_pin) else $error("pin not high");
  pin_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_src_r == `PIN_CAL_DONE |=> status_pin == $past(done_r)) else $error("pin not done");
  pin_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_src_r == `PIN_LOCK |=> status_pin == $past(lock_r)) else $error("pin not lock");
  // lock indication masking
  lock_masked_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    running |=> !lock_r) else $error("lock shown during calibration");
  settle_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    settle_r != '0 |=> !lock_r) else $error("lock shown while settling");
  // sequencer and result store
  go_refused_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && cal_go && !cnt_zero |=> cnt_r == $past(cnt_r) - 1'b1) else $error("start taken while busy");
  pass_length_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sp.wr_en |-> pass_cyc_r == pass_len_r - 1'b1) else $error("pass length wrong");
  store_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sp.wr_en |-> running && cnt_zero) else $error("store written outside calibration");
  dual_second_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == CAL_RUN_FIRST && cnt_zero && dual |=> state_r == CAL_RUN_SECOND) else $error("dual skipped");
  second_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == CAL_RUN_SECOND |-> sp.wr_sel) else $error("second pass wrote first set");
  single_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == CAL_RUN_FIRST && !dual |-> sp.wr_sel == fset_sel) else $error("single pass wrote wrong set");
  // register port and outputs
  read_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rd_stb |=> rdata == 8'h00) else $error("read data without strobe");
  bias_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fset_sel |-> osc_bias == osc_r[7:4]) else $error("wrong bias nibble");
endmodule // synth_ctrl
`default_nettype wire

// ==== synth_ctrl_pkg.sv ====
// synth_ctrl_pkg.sv: types shared by the synthesizer control modules
// assumes: nothing beyond the constants header
`default_nettype none
package synth_ctrl_pkg;
  // calibration sequencer states
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN_FIRST, CAL_RUN_SECOND} cal_state_t;
  // stored calibration result for one frequency set
  typedef logic [7:0] cal_word_t;
endpackage
`default_nettype wire

// ==== synth_ctrl_regs.svh ====
// synth_ctrl_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the design modules
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH
// register offsets (8-bit word index on the plain port)
`define OFS_MAIN        8'h00
`define OFS_CALIBRATE   8'h01
`define OFS_OSC_BIAS    8'h02
`define OFS_BUF_BIAS    8'h03
`define OFS_PIN_SRC     8'h04
`define OFS_STATUS      8'h05
`define OFS_CHAN_FIRST  8'h06
`define OFS_CHAN_SECOND 8'h07
// main control fields
`define MAIN_SOFT_RST_N 0
`define MAIN_FSET_SEL   1
`define MAIN_PD_TX      2
`define MAIN_PD_SYNTH   3
`define MAIN_PD_XOSC    4
// calibration control fields
`define CAL_GO          7
`define CAL_DUAL_BIT    6
`define CAL_WAIT_HI     5
`define CAL_WAIT_LO     4
`define CAL_FAST_BIT    3
`define CAL_ITER_HI     2
`define CAL_ITER_LO     0
// status fields
`define ST_CAL_DONE     7
`define ST_LOCK         4
// reset values
`define MAIN_RST        8'h1e
`define CAL_RST         8'h35
`define OSC_BIAS_RST    8'h88
`define BUF_BIAS_RST    8'h04
`define PIN_SRC_RST     4'h0
// status pin source codes
`define PIN_LOW         4'h0
`define PIN_HIGH        4'h1
`define PIN_LOCK        4'h2
`define PIN_CAL_DONE    4'h5
// calibration time in us for the fast routine at the 7.3728 MHz reference
`define CAL_US_W0       1000
`define CAL_US_W1       1500
`define CAL_US_W2       2900
`define CAL_US_W3       3900
`define CLK_MHZ         100
// settling after frequency set switch and after synth power-up, in us
`define FSET_SETTLE_US  1300
`define TURN_ON_US      3200
`endif
